// ### rtl/bofm_pkg.sv
package bofm_pkg;
  localparam logic [7:0] FLAG_OCTET = 8'h7e;
  localparam logic [7:0] IDLE_MARK = 8'hff;
  localparam logic [6:0] ABORT_ONES = 7'h7f;
  localparam logic [2:0] ONES_STUFF = 3'h5;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;
  localparam logic [3:0] NRZI_MID = 4'h8;
  localparam logic [4:0] LEFT_OCTET = 5'h08;
  localparam logic [4:0] LEFT_FCS = 5'h10;
  localparam logic [4:0] LEFT_ONE = 5'h01;
  localparam int FIFO_DEPTH = 8;
  localparam int TXW_W = 9;
  localparam int TXW_LAST = 8;
  localparam int RXW_W = 11;
  localparam int RXW_OVR = 10;
  localparam int RXW_EOF = 9;
  localparam int RXW_ERR = 8;
  typedef enum logic [1:0] {
    PROTO_HDLC = 2'h0,
    PROTO_SDLC = 2'h1,
    PROTO_X25 = 2'h2,
    PROTO_CHAR = 2'h3
  } bofm_proto_t;
  typedef enum logic [1:0] {
    FT_INFO = 2'h0,
    FT_SUPV = 2'h1,
    FT_UNNUM = 2'h3
  } bofm_ftype_t;
  typedef enum logic [2:0] {
    TX_FLAG = 3'b001,
    TX_DATA = 3'b010,
    TX_FCS = 3'b100
  } bofm_tx_st_t;
  typedef enum logic [3:0] {
    PS_ADDR = 4'b0001,
    PS_CTL1 = 4'b0010,
    PS_CTL2 = 4'b0100,
    PS_INFO = 4'b1000
  } bofm_ps_t;
endpackage : bofm_pkg

// ### rtl/bofm_stream_if.sv
`timescale 1ns/10ps
interface bofm_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bofm_stream_if

// ### rtl/bofm_fifo.sv
`timescale 1ns/10ps
module bofm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  bofm_stream_if.snk in_s,
  bofm_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic rdy_r;
  logic empty_r;
  logic wr;
  logic rd;

  assign wr = in_s.valid & rdy_r;
  assign rd = out_s.ready & ~empty_r;
  assign in_s.ready = rdy_r;
  assign out_s.valid = ~empty_r;
  assign out_s.data = mem[rp_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (wr && !rd) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (rd && !wr) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wp_r] <= in_s.data;
    end
  end

  // flags are registered so the top's ready port comes from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
      empty_r <= 1'b1;
    end else begin
      if (wr) wp_r <= wp_r + 1'b1;
      if (rd) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      rdy_r <= cnt_nxt != (AW+1)'(DEPTH);
      empty_r <= cnt_nxt == '0;
    end
  end
endmodule : bofm_fifo

// ### rtl/bofm_crc.sv
`timescale 1ns/10ps
module bofm_crc
  import bofm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic init,
  input wire logic en,
  input wire logic bit_in,
  output logic [15:0] crc_r,
  output logic [15:0] crc_nxt
);
  // bit-serial, lsb first, reflected polynomial
  assign crc_nxt = (crc_r >> 1) ^ ((crc_r[0] ^ bit_in) ? CRC_POLY : '0);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crc_r <= CRC_INIT;
    end else if (init) begin
      crc_r <= CRC_INIT;
    end else if (en) begin
      crc_r <= crc_nxt;
    end
  end
endmodule : bofm_crc

// ### rtl/bofm_top.sv
`timescale 1ns/10ps
// Functional notes
// (R01) bit-oriented setups strip received stuffed zeros and stuff sent data
// (R02) extended address: octet with lsb 0 is followed by another
// (R03) extended address: octet with lsb 1 ends the address field
// (R04) extended control makes the control field two octets; the code keeps unnumbered frames at one octet
// (R05) sequence numbers modulo 8, or 128 with extended control
// (R06) bit-oriented data is sampled with a line clock, never async framing
// (R07) nrzi, sdlc only, recovers bit timing from data transitions
// (R08) terminal data sampled on modem or terminal clock per select
// (R09) terminal and modem sides may run at 75 and 1200 bps together
// (R10) nrzi need not work at 16000, 12000 or 2000 bps
// (R11) any 8-bit value passes as data, no character interpretation
// (R12) every received frame's check sequence is verified
// (R13) transmitted frames get check octets appended automatically
// (R14) control field decoded: type, sequence numbers, poll/final
// (R15) x.25 information frames carry packet data in information field
// (R16) frames delimited by 7e flags, crc-ccitt, mismatch flags an error
// (R17) nrzi: a 0 toggles the line, a 1 holds it
module bofm_top
  import bofm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic line_clk,
  input wire logic modem_data,
  input wire logic term_data,
  input wire logic term_clk,
  input wire logic [1:0] protocol,
  input wire logic ext_addr_en,
  input wire logic ext_ctrl_en,
  input wire logic nrzi_en,
  input wire logic terminal_clock_source_select,
  input wire logic mon_terminal,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_line,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_eof,
  output logic rx_crc_err,
  output logic rx_overrun,
  output logic rx_info,
  output logic rx_packet,
  output logic dec_valid,
  output logic [7:0] dec_addr,
  output logic [3:0] dec_addr_len,
  output logic [1:0] dec_type,
  output logic [6:0] dec_ns,
  output logic [6:0] dec_nr,
  output logic dec_pf
);
  // ---------------- link domain: pin and control synchronisers
  logic [2:0] pin_q1_r, pin_q2_r;
  logic [4:0] cfg_q1_r, cfg_q2_r;
  logic [1:0] hsl_q1_r, hsl_q2_r;
  logic tclk_d_r;
  logic bit_or, nrzi, tcs, mterm, rx_pin, tclk_rise;
  logic rx_ack_r, tx_req_r;
  logic [TXW_W-1:0] tx_hold_r;

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      pin_q1_r <= '0;
      pin_q2_r <= '0;
      cfg_q1_r <= '0;
      cfg_q2_r <= '0;
      hsl_q1_r <= '0;
      hsl_q2_r <= '0;
      tclk_d_r <= 1'b0;
    end else begin
      pin_q1_r <= {term_clk, term_data, modem_data};
      pin_q2_r <= pin_q1_r;
      cfg_q1_r <= {protocol, nrzi_en, terminal_clock_source_select,
                   mon_terminal};
      cfg_q2_r <= cfg_q1_r;
      hsl_q1_r <= {rx_ack_r, tx_req_r};
      hsl_q2_r <= hsl_q1_r;
      tclk_d_r <= pin_q2_r[2];
    end
  end

  assign bit_or = cfg_q2_r[4:3] != PROTO_CHAR;
  assign nrzi = cfg_q2_r[2] && (cfg_q2_r[4:3] == PROTO_SDLC); // R07
  assign tcs = cfg_q2_r[1];
  assign mterm = cfg_q2_r[0];
  assign rx_pin = mterm ? pin_q2_r[1] : pin_q2_r[0];
  assign tclk_rise = pin_q2_r[2] & ~tclk_d_r;

  // ---------------- receive bit recovery
  // the dpll assumes the link clock is 16x the nrzi bit rate; the odd
  // rates that do not divide evenly are simply not supported
  logic [3:0] rx_ph_r;
  logic rx_last_r, rx_lvl_r;
  logic strobe, rbit;

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      rx_ph_r <= '0;
      rx_last_r <= 1'b1;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_last_r <= rx_pin;
      rx_ph_r <= (rx_pin != rx_last_r) ? '0 : rx_ph_r + 1'b1; // R07 R10
      if (strobe) rx_lvl_r <= rx_pin;
    end
  end

  always_comb begin
    if (nrzi) begin
      strobe = rx_ph_r == NRZI_MID; // R07
      rbit = rx_pin == rx_lvl_r; // R17
    end else begin
      strobe = (mterm && tcs) ? tclk_rise : 1'b1; // R06 R08 R09
      rbit = rx_pin;
    end
  end

  // ---------------- receive framing: flags, destuffing, octets
  logic [7:0] rx_win_r, rx_vm_r, rx_sr_r;
  logic [2:0] rx_ones_r, rx_bc_r;
  logic rx_inf_r, rx_got_r, rx_eofp_r, rx_abt_r, rx_lost_r, rx_req_r;
  logic [RXW_W-1:0] rx_word_r;
  logic [7:0] win_nxt, sr_nxt;
  logic flag_hit, abort_hit, data_v, dbit, stuff_skip, take, byte_done;
  logic emit, frame_rst, rx_free;
  logic [15:0] rx_crc;

  assign win_nxt = {rbit, rx_win_r[7:1]};
  assign flag_hit = strobe & bit_or & (win_nxt == FLAG_OCTET); // R16
  assign abort_hit = strobe & bit_or & (win_nxt[7:1] == ABORT_ONES);
  assign data_v = strobe & (bit_or ? rx_vm_r[0] & rx_inf_r : 1'b1);
  assign dbit = bit_or ? rx_win_r[0] : rbit;
  assign stuff_skip = bit_or & ~dbit & (rx_ones_r == ONES_STUFF); // R01
  assign take = data_v & ~stuff_skip;
  assign byte_done = take & (rx_bc_r == BIT_LAST);
  assign sr_nxt = {dbit, rx_sr_r[7:1]}; // R11
  assign emit = byte_done | rx_eofp_r;
  assign frame_rst = (rx_eofp_r & rx_free) | (flag_hit & ~rx_got_r);
  assign rx_free = rx_req_r == hsl_q2_r[1];

  bofm_crc u_rx_crc (
    .clk(line_clk),
    .nrst(nrst),
    .init(frame_rst),
    .en(take & bit_or),
    .bit_in(dbit),
    .crc_r(rx_crc),
    .crc_nxt()
  );

  // the window delays data by one octet so a closing flag never leaks in
  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      rx_win_r <= '0;
      rx_vm_r <= '0;
      rx_inf_r <= 1'b0;
      rx_got_r <= 1'b0;
      rx_eofp_r <= 1'b0;
      rx_abt_r <= 1'b0;
    end else begin
      // the end marker trails the last octet by one line clock cycle, so it waits
      // for the handshake instead of being dropped
      if (rx_free) rx_eofp_r <= 1'b0;
      if (strobe) begin
        rx_win_r <= win_nxt;
        rx_vm_r <= {1'b1, rx_vm_r[7:1]};
      end
      if (take) rx_got_r <= 1'b1;
      if (flag_hit) begin // R16
        rx_vm_r <= '0;
        rx_inf_r <= 1'b1;
        rx_got_r <= 1'b0;
        rx_eofp_r <= rx_inf_r & rx_got_r;
        rx_abt_r <= 1'b0;
      end else if (abort_hit) begin
        rx_inf_r <= 1'b0;
        rx_got_r <= 1'b0;
        rx_eofp_r <= rx_got_r;
        rx_abt_r <= rx_got_r;
      end
    end
  end

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      rx_ones_r <= '0;
      rx_sr_r <= '0;
      rx_bc_r <= '0;
    end else begin
      if (flag_hit) begin
        rx_ones_r <= '0;
      end else if (data_v) begin
        rx_ones_r <= (dbit & ~stuff_skip) ? rx_ones_r + 1'b1 : '0; // R01
      end
      if (take) begin
        rx_sr_r <= sr_nxt;
        rx_bc_r <= rx_bc_r + 1'b1;
      end else if (frame_rst) begin
        rx_bc_r <= '0;
      end
    end
  end

  // an octet done before the system side takes the last word is lost and reported later
  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      rx_req_r <= 1'b0;
      rx_lost_r <= 1'b0;
      rx_word_r <= '0;
    end else if (emit) begin
      if (rx_free) begin
        rx_req_r <= ~rx_req_r;
        rx_lost_r <= 1'b0;
        if (byte_done) begin
          rx_word_r <= {rx_lost_r, 1'b0, 1'b0, sr_nxt};
        end else begin
          rx_word_r <= {rx_lost_r, 1'b1, (rx_crc != CRC_GOOD) // R12 R16
                        | (rx_bc_r != '0) | rx_abt_r, 8'h00};
        end
      end else if (byte_done) begin
        rx_lost_r <= 1'b1;
      end
    end
  end

  // ---------------- transmit framing in the link domain
  bofm_tx_st_t tx_st_r;
  logic [15:0] tx_sr_r;
  logic [4:0] tx_left_r;
  logic [2:0] tx_ones_r;
  logic [3:0] tx_ph_r;
  logic tx_lst_r, tx_ack_r, tx_line_r;
  logic tick, stuff, send_b, shift_go, load, avail;
  logic [15:0] tx_crc_nxt;
  logic [7:0] idle_oct;

  assign avail = hsl_q2_r[0] != tx_ack_r;
  assign tick = nrzi ? (tx_ph_r == '0) : 1'b1;
  assign stuff = bit_or & (tx_ones_r == ONES_STUFF); // R01
  assign send_b = stuff ? 1'b0 : tx_sr_r[0];
  assign shift_go = tick & ~stuff;
  assign load = shift_go & (tx_left_r == LEFT_ONE);
  assign idle_oct = bit_or ? FLAG_OCTET : IDLE_MARK;

  bofm_crc u_tx_crc (
    .clk(line_clk),
    .nrst(nrst),
    .init(tx_st_r == TX_FLAG),
    .en(shift_go & (tx_st_r == TX_DATA)),
    .bit_in(send_b),
    .crc_r(),
    .crc_nxt(tx_crc_nxt)
  );

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      tx_ph_r <= '0;
      tx_ones_r <= '0;
      tx_line_r <= 1'b1;
    end else begin
      tx_ph_r <= tx_ph_r + 1'b1;
      if (tick) begin
        tx_line_r <= nrzi ? (send_b ? tx_line_r : ~tx_line_r) // R17
                          : send_b;
        if (stuff || tx_st_r == TX_FLAG || !send_b) begin
          tx_ones_r <= '0;
        end else begin
          tx_ones_r <= tx_ones_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge line_clk or negedge nrst) begin
    if (!nrst) begin
      tx_st_r <= TX_FLAG;
      tx_sr_r <= {8'h00, FLAG_OCTET};
      tx_left_r <= LEFT_OCTET;
      tx_lst_r <= 1'b0;
      tx_ack_r <= 1'b0;
    end else if (shift_go) begin
      tx_sr_r <= tx_sr_r >> 1;
      tx_left_r <= tx_left_r - 1'b1;
      if (load) begin
        tx_left_r <= LEFT_OCTET;
        unique case (tx_st_r)
          TX_FLAG, TX_DATA: begin
            if (avail && !(tx_st_r == TX_DATA && tx_lst_r)) begin
              tx_sr_r <= {8'h00, tx_hold_r[7:0]}; // R11
              tx_lst_r <= tx_hold_r[TXW_LAST];
              tx_ack_r <= ~tx_ack_r;
              tx_st_r <= TX_DATA;
            end else if (tx_st_r == TX_DATA && bit_or) begin
              tx_sr_r <= ~tx_crc_nxt; // R13 R16
              tx_left_r <= LEFT_FCS;
              tx_st_r <= TX_FCS;
            end else begin
              tx_sr_r <= {8'h00, idle_oct};
              tx_st_r <= TX_FLAG;
            end
          end
          TX_FCS: begin
            tx_sr_r <= {8'h00, FLAG_OCTET};
            tx_st_r <= TX_FLAG;
          end
        endcase
      end
    end
  end

  assign tx_line = tx_line_r;

  // ---------------- system domain: crossings and transmit buffer
  logic [1:0] hs_q1_r, hs_q2_r;
  logic rx_new;

  bofm_stream_if #(.W(TXW_W)) txin_s ();
  bofm_stream_if #(.W(TXW_W)) txout_s ();

  assign txin_s.valid = tx_valid;
  assign txin_s.data = {tx_last, tx_data};
  assign tx_ready = txin_s.ready;
  // the buffer drains only when the link has taken the held octet
  assign txout_s.ready = tx_req_r == hs_q2_r[0];

  bofm_fifo #(.WIDTH(TXW_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_s(txin_s),
    .out_s(txout_s)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_q1_r <= '0;
      hs_q2_r <= '0;
      tx_req_r <= 1'b0;
      tx_hold_r <= '0;
      rx_ack_r <= 1'b0;
    end else begin
      hs_q1_r <= {rx_req_r, tx_ack_r};
      hs_q2_r <= hs_q1_r;
      if (txout_s.valid && txout_s.ready) begin
        tx_hold_r <= txout_s.data;
        tx_req_r <= ~tx_req_r;
      end
      if (rx_new) rx_ack_r <= ~rx_ack_r;
    end
  end

  assign rx_new = hs_q2_r[1] != rx_ack_r;

  // ---------------- frame decode
  bofm_ps_t ps_r;
  logic ext_a, ext_c, is_info, is_x25;
  logic [7:0] rb, c1_r;

  assign rb = rx_word_r[7:0];
  assign ext_a = ext_addr_en && (protocol == PROTO_HDLC);
  assign ext_c = ext_ctrl_en && (protocol == PROTO_HDLC);
  assign is_x25 = protocol == PROTO_X25;
  assign is_info = ps_r == PS_INFO;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ps_r <= PS_ADDR;
    end else if (rx_new) begin
      if (rx_word_r[RXW_EOF]) begin
        ps_r <= PS_ADDR;
      end else begin
        unique case (ps_r)
          PS_ADDR: if (!(ext_a && !rb[0])) ps_r <= PS_CTL1; // R02 R03
          PS_CTL1: ps_r <= (ext_c && rb[1:0] != FT_UNNUM) // R04
                           ? PS_CTL2 : PS_INFO;
          PS_CTL2: ps_r <= PS_INFO;
          PS_INFO: ps_r <= PS_INFO;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c1_r <= '0;
      dec_valid <= 1'b0;
      dec_addr <= '0;
      dec_addr_len <= '0;
      dec_type <= FT_INFO;
      dec_ns <= '0;
      dec_nr <= '0;
      dec_pf <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
      if (rx_new && !rx_word_r[RXW_EOF]) begin
        unique case (ps_r)
          PS_ADDR: begin
            dec_addr <= rb;
            dec_addr_len <= dec_addr_len + 1'b1;
          end
          PS_CTL1: begin // R14
            c1_r <= rb;
            dec_type <= rb[0] ? rb[1:0] : FT_INFO;
            dec_ns <= rb[0] ? '0 : {4'h0, rb[3:1]}; // R05
            dec_nr <= (rb[1:0] == FT_UNNUM) ? '0 : {4'h0, rb[7:5]};
            dec_pf <= rb[4];
            dec_valid <= !(ext_c && rb[1:0] != FT_UNNUM);
          end
          PS_CTL2: begin // R04 R05 R14
            dec_ns <= c1_r[0] ? '0 : c1_r[7:1];
            dec_nr <= rb[7:1];
            dec_pf <= rb[0];
            dec_valid <= 1'b1;
          end
          PS_INFO: ;
        endcase
      end else if (rx_new) begin
        dec_addr_len <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_byte <= '0;
      rx_eof <= 1'b0;
      rx_crc_err <= 1'b0;
      rx_overrun <= 1'b0;
      rx_info <= 1'b0;
      rx_packet <= 1'b0;
    end else begin
      rx_valid <= rx_new;
      if (rx_new) begin
        rx_byte <= rb;
        rx_eof <= rx_word_r[RXW_EOF];
        rx_crc_err <= rx_word_r[RXW_ERR]; // R12
        rx_overrun <= rx_word_r[RXW_OVR];
        rx_info <= is_info && !rx_word_r[RXW_EOF];
        rx_packet <= is_info && !rx_word_r[RXW_EOF] && is_x25 // R15
                     && dec_type == FT_INFO;
      end
    end
  end
endmodule : bofm_top

// ### verif/bofm_top_asserts.sv
`timescale 1ns/10ps
module bofm_top_asserts
  import bofm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] protocol,
  input wire logic ext_addr_en,
  input wire logic ext_ctrl_en,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_eof,
  input wire logic rx_crc_err,
  input wire logic rx_info,
  input wire logic rx_packet,
  input wire logic dec_valid,
  input wire logic [7:0] dec_addr,
  input wire logic [3:0] dec_addr_len,
  input wire logic [1:0] dec_type,
  input wire logic [6:0] dec_ns,
  input wire logic [6:0] dec_nr
);
  logic ext_a;
  logic ext_c;
  // extensions count only in the plain hdlc setup
  assign ext_a = protocol == PROTO_HDLC && ext_addr_en;
  assign ext_c = protocol == PROTO_HDLC && ext_ctrl_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid longer than one cycle");
  eof_empty_a: assert property (rx_valid && rx_eof |-> rx_byte == 8'h00)
    else $error("eof word carries data");
  err_eof_a: assert property (rx_valid && rx_crc_err |-> rx_eof)
    else $error("check error outside eof word");
  packet_x25_a: assert property (rx_valid && rx_packet |->
    rx_info && protocol == PROTO_X25)
    else $error("packet flag outside x25 information");
  seq_mod8_a: assert property (dec_valid && !ext_c |->
    dec_ns < 7'h08 && dec_nr < 7'h08)
    else $error("sequence number above modulo 8");
  addr_one_a: assert property (dec_valid && !ext_a |-> dec_addr_len == 4'h1)
    else $error("address longer than one octet");
  addr_end_a: assert property (dec_valid && ext_a |->
    dec_addr[0] && dec_addr_len != 4'h0)
    else $error("extended address not closed by lsb 1");
  sup_ns_a: assert property (dec_valid && dec_type != FT_INFO |-> dec_ns == 7'h00)
    else $error("send count on non information frame");
  unn_nr_a: assert property (dec_valid && dec_type == FT_UNNUM |->
    dec_nr == 7'h00)
    else $error("receive count on unnumbered frame");
  dec_pulse_a: assert property (dec_valid |=> !dec_valid ##1 !dec_valid)
    else $error("decode strobe repeated");
endmodule : bofm_top_asserts
bind bofm_top bofm_top_asserts i_chk (.clk(clk), .nrst(nrst),
  .protocol(protocol), .ext_addr_en(ext_addr_en), .ext_ctrl_en(ext_ctrl_en),
  .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof),
  .rx_crc_err(rx_crc_err), .rx_info(rx_info), .rx_packet(rx_packet),
  .dec_valid(dec_valid), .dec_addr(dec_addr), .dec_addr_len(dec_addr_len),
  .dec_type(dec_type), .dec_ns(dec_ns), .dec_nr(dec_nr));

// ### verif/bofm_line_model.sv
`timescale 1ns/10ps
module bofm_line_model
  import bofm_pkg::*;
(
  input wire logic line_clk,
  input wire logic tx_line,
  output logic modem_data
);
  logic [7:0] oq[$];
  logic [7:0] lastf[$];
  logic q[$];
  logic [7:0] sh = 8'h00;
  logic [7:0] b;
  int ones = 0;
  int rones = 0;
  int nframes = 0;
  bit pend = 0;
  task automatic put_oct(input logic [7:0] v, input bit stf);
    for (int i = 0; i < 8; i++) begin
      @(negedge line_clk);
      modem_data = v[i];
      ones = v[i] ? ones + 1 : 0;
      if (stf && ones == 5) begin
        @(negedge line_clk);
        modem_data = 1'b0;
        ones = 0;
      end
    end
  endtask : put_oct
  // the line never rests: flags fill every gap between frames
  initial begin
    modem_data = 1'b1;
    forever begin
      put_oct(FLAG_OCTET, 1'b0);
      ones = 0;
      if (pend) begin
        while (oq.size() > 0) put_oct(oq.pop_front(), 1'b1);
        pend = 0;
      end
    end
  end
  // sampled half a bit after the launching edge
  always @(negedge line_clk) begin
    sh = {tx_line, sh[7:1]};
    if (sh == FLAG_OCTET) begin
      // the flag's first seven bits were already taken as data
      repeat (7) if (q.size() > 0) void'(q.pop_back());
      if (q.size() > 0 && q.size() % 8 == 0) begin
        lastf.delete();
        for (int i = 0; i < q.size(); i += 8) begin
          for (int j = 0; j < 8; j++) b[j] = q[i+j];
          lastf.push_back(b);
        end
        nframes++;
      end
      q.delete();
      rones = 0;
    end else begin
      if (!(rones == 5 && !tx_line)) q.push_back(tx_line);
      rones = tx_line ? rones + 1 : 0;
    end
  end
endmodule : bofm_line_model

// ### verif/bit_oriented_frame_monitor_test.sv
`timescale 1ns/10ps
module bit_oriented_frame_monitor_test
  import bofm_pkg::*;
;
  logic clk, nrst, line_clk, modem_data, tx_line, tx_ready;
  logic ext_addr_en, ext_ctrl_en, tx_valid, tx_last, dec_pf;
  logic rx_valid, rx_eof, rx_crc_err, rx_overrun, rx_info, rx_packet;
  logic dec_valid;
  logic [1:0] protocol, dec_type;
  logic [7:0] tx_data, rx_byte, dec_addr;
  logic [3:0] dec_addr_len;
  logic [6:0] dec_ns, dec_nr;
  logic [15:0] seed;
  logic [12:0] got[$];
  logic [28:0] dgot[$];
  int failures, tests_run;
  bofm_top i_dut (.clk(clk), .nrst(nrst), .line_clk(line_clk),
    .modem_data(modem_data), .term_data(modem_data), .term_clk(1'b0),
    .protocol(protocol), .ext_addr_en(ext_addr_en),
    .ext_ctrl_en(ext_ctrl_en), .nrzi_en(1'b0),
    .terminal_clock_source_select(1'b0), .mon_terminal(1'b0),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_line(tx_line), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_eof(rx_eof), .rx_crc_err(rx_crc_err),
    .rx_overrun(rx_overrun), .rx_info(rx_info), .rx_packet(rx_packet),
    .dec_valid(dec_valid), .dec_addr(dec_addr),
    .dec_addr_len(dec_addr_len), .dec_type(dec_type), .dec_ns(dec_ns),
    .dec_nr(dec_nr), .dec_pf(dec_pf));
  bofm_line_model i_line (.line_clk(line_clk), .tx_line(tx_line),
    .modem_data(modem_data));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    line_clk = 1'b0;
    #7;
    forever #62.5 line_clk = ~line_clk;
  end
  always @(negedge clk) begin
    if (rx_valid === 1'b1) got.push_back({rx_overrun, rx_packet, rx_info,
      rx_crc_err, rx_eof, rx_byte});
    if (dec_valid === 1'b1) dgot.push_back({dec_addr, dec_addr_len,
      dec_type, dec_ns, dec_nr, dec_pf});
  end
  function automatic logic [7:0] rnd8();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : rnd8
  function automatic logic [15:0] fcs_of(input logic [7:0] f[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (f[i]) for (int j = 0; j < 8; j++)
      c = (c[0] ^ f[i][j]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    return ~c;
  endfunction : fcs_of
  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] g, input logic [31:0] e,
    input string m);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : check
  task automatic rx_frame(input int typ, ns, nr, pf, nal, ninfo, bit bad);
    logic [7:0] f[$];
    logic [12:0] ex[$];
    logic [15:0] c;
    logic [7:0] a;
    logic [6:0] ens, enr;
    bit ea, ec, xi;
    int hdr, n;
    ea = protocol == PROTO_HDLC && ext_addr_en;
    ec = protocol == PROTO_HDLC && ext_ctrl_en && typ != 3;
    for (int k = 0; k < nal; k++) begin
      a = rnd8();
      if (ea) a[0] = k == nal - 1;
      f.push_back(a);
    end
    ens = typ == 0 ? 7'(ec ? ns % 128 : ns % 8) : 7'h00;
    enr = typ != 3 ? 7'(ec ? nr % 128 : nr % 8) : 7'h00;
    if (typ == 3) f.push_back({3'h0, pf[0], 4'hf});
    else if (ec) begin
      f.push_back(typ == 0 ? {ens, 1'b0} : 8'h01);
      f.push_back({enr, pf[0]});
    end else f.push_back({enr[2:0], pf[0], typ == 0 ? {ens[2:0], 1'b0} : 4'h1});
    hdr = f.size();
    for (int k = 0; k < ninfo; k++)
      f.push_back(k == 0 ? FLAG_OCTET : (k == 1 ? 8'hff : rnd8()));
    c = fcs_of(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    xi = protocol == PROTO_X25 && typ == 0;
    foreach (f[k]) ex.push_back({1'b0, xi && k >= hdr, k >= hdr, 2'b00, f[k]});
    got.delete();
    dgot.delete();
    i_line.oq = f;
    i_line.pend = 1'b1;
    n = 0;
    while (n < 20000 && !(got.size() > 0 && got[$][8] === 1'b1)) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      wrap_up();
    end
    check(got.size(), f.size() + 1, "word count");
    foreach (ex[k]) check(got[k], ex[k], "rx word");
    check(got[$][9:0], {bad, 1'b1, 8'h00}, "eof word");
    check(dgot.size(), 1, "decode count");
    check(dgot[0], {a, 4'(nal), 2'(typ), ens, enr, pf[0]}, "decode");
  endtask : rx_frame
  task automatic tx_frame(input int nw);
    logic [7:0] w[$];
    logic [15:0] c;
    bit acc, full;
    int i, k, n0;
    for (int j = 0; j < nw; j++) w.push_back(rnd8());
    c = fcs_of(w);
    n0 = i_line.nframes;
    i = 0;
    k = 0;
    full = 0;
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = w[0];
    tx_last = 1'b0;
    // a refused word is held unchanged until the fifo takes it
    while (i < nw && k < 5000) begin
      @(posedge clk);
      acc = tx_ready;
      k++;
      @(negedge clk);
      if (acc) begin
        i++;
        tx_data = i < nw ? w[i] : 8'h00;
        tx_last = i == nw - 1;
      end else full = 1;
      if (i == nw) tx_valid = 1'b0;
    end
    check(full, 1, "fifo full");
    k = 0;
    while (i_line.nframes == n0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) begin
      failures++;
      wrap_up();
    end
    w.push_back(c[7:0]);
    w.push_back(c[15:8]);
    check(i_line.lastf.size(), w.size(), "tx length");
    foreach (w[j]) check(i_line.lastf[j], w[j], "tx octet");
  endtask : tx_frame
  initial begin
    nrst = 1'b0;
    protocol = PROTO_HDLC;
    ext_addr_en = 1'b0;
    ext_ctrl_en = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    tx_last = 1'b0;
    failures = 0;
    tests_run = 0;
    seed = 16'he2bb;
    // held over line clock cycles so both domains see the reset
    repeat (3) @(negedge line_clk);
    @(negedge clk);
    nrst = 1'b1;
    repeat (100) @(negedge clk);
    rx_frame(0, 3, 5, 1, 1, 4, 0);
    rx_frame(0, 100, 77, 0, 1, 3, 1);
    rx_frame(1, 0, 6, 1, 1, 0, 0);
    rx_frame(3, 0, 0, 1, 1, 1, 0);
    @(negedge clk);
    ext_addr_en = 1'b1;
    ext_ctrl_en = 1'b1;
    repeat (40) @(negedge clk);
    rx_frame(0, 100, 77, 1, 3, 2, 0);
    rx_frame(1, 0, 99, 0, 2, 0, 0);
    rx_frame(3, 0, 0, 1, 1, 1, 0);
    @(negedge clk);
    protocol = PROTO_SDLC;
    repeat (40) @(negedge clk);
    rx_frame(0, 9, 3, 1, 1, 2, 0);
    @(negedge clk);
    protocol = PROTO_X25;
    repeat (40) @(negedge clk);
    rx_frame(0, 4, 1, 0, 1, 3, 0);
    rx_frame(1, 0, 2, 0, 1, 0, 0);
    tx_frame(12);
    wrap_up();
  end
endmodule : bit_oriented_frame_monitor_test
